// ==== dcc_top.sv ====
// dual comparator control: control register, results, change flag, interrupt
// assumes comparator outputs are asynchronous levels; pin directions come from
// the port f direction register outside this block
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // analog comparator side
  input wire logic cmp1_raw_i,
  input wire logic cmp2_raw_i,
  output dcc_pkg::dcc_route_s route_o,
  output logic cmp1_out_o,
  output logic cmp2_out_o,
  // port f direction passthrough
  input wire logic [7:0] port_f_direction_i,
  output logic [7:0] port_f_direction_o,
  // status
  output logic result_valid_o,
  output logic cmp_change_flag_o,
  output logic irq_o
);
  import dcc_pkg::*;
  dcc_ctrl_s ctrl;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] latched;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] settle_cnt;
  logic [7:0] rdata;
  wire sel_ctrl = addr_i == ADDR_CTRL;
  wire sel_stat = addr_i == ADDR_IRQ_STATUS;
  wire sel_mask = addr_i == ADDR_IRQ_MASK;
  wire sel_settle = addr_i == ADDR_SETTLE;
  wire wr_ctrl = wr_i && sel_ctrl;
  wire wr_stat = wr_i && sel_stat;
  wire wr_mask = wr_i && sel_mask;
  wire ctrl_access = (wr_i || rd_i) && sel_ctrl;
  wire [1:0] raw = {cmp2_raw_i, cmp1_raw_i};
  wire [1:0] sync = sync_b;
  wire [1:0] invert = {ctrl.cmp2_invert, ctrl.cmp1_invert};
  wire [1:0] result = sync ^ invert;
  wire mismatch = result != latched;
  wire [5:0] next_ctrl_bits = wdata_i[5:0] & CTRL_WR_MASK[5:0];
  dcc_ctrl_s next_ctrl;
  assign next_ctrl = dcc_ctrl_s'(next_ctrl_bits);
  wire mode_change = wr_ctrl && (next_ctrl.cmp_mode_sel != ctrl.cmp_mode_sel);
  wire [7:0] ctrl_read = {result, 6'(ctrl)};
  wire [7:0] event_bits = {7'h00, mismatch};
  wire [7:0] next_status = (irq_status & ~(wr_stat ? wdata_i : 8'h00)) | event_bits;
  always_comb
  begin
    rdata = 8'h00;
    if (sel_ctrl)
      rdata = ctrl_read;
    else if (sel_stat)
      rdata = irq_status;
    else if (sel_mask)
      rdata = irq_mask;
    else if (sel_settle)
      rdata = settle_cnt;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end
    else
    begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl <= dcc_ctrl_s'(CTRL_RESET[5:0]);
    else if (wr_ctrl)
      ctrl <= next_ctrl;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      latched <= 2'h0;
    else if (ctrl_access)
      latched <= result;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end
    else
    begin
      irq_status <= next_status & IRQ_BITS_MASK;
      if (wr_mask)
        irq_mask <= wdata_i & IRQ_BITS_MASK;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      settle_cnt <= 8'h00;
    else if (mode_change)
      settle_cnt <= SETTLE_LOAD;
    else if (settle_cnt != 8'h00)
      settle_cnt <= settle_cnt - 8'h01;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? rdata : 8'h00;
  end
  dcc_route u_route (
    .ctrl_i(ctrl),
    .route_o(route_o)
  );
  assign cmp1_out_o = cmp1_raw_i ^ ctrl.cmp1_invert;
  assign cmp2_out_o = cmp2_raw_i ^ ctrl.cmp2_invert;
  assign port_f_direction_o = port_f_direction_i;
  assign result_valid_o = settle_cnt == 8'h00;
  assign cmp_change_flag_o = irq_status[IRQ_BIT_CHANGE];
  assign irq_o = |(irq_status & irq_mask);
endmodule // dcc_top
`default_nettype wire

// ==== dcc_pkg.sv ====
// dual comparator control package: register layout, modes, offsets, timing
// assumes an 8-bit software register port and one 10 MHz clock
package dcc_pkg;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_IRQ_STATUS = 2'h1;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
  localparam logic [1:0] ADDR_SETTLE = 2'h3;
  localparam int BIT_CMP2_RESULT = 7;
  localparam int BIT_CMP1_RESULT = 6;
  localparam int BIT_CMP2_INVERT = 5;
  localparam int BIT_CMP1_INVERT = 4;
  localparam int BIT_NEG_SWITCH = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'h3f;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h01;
  localparam int IRQ_BIT_CHANGE = 0;
  localparam int CLK_HZ = 10_000_000;
  localparam int SETTLE_TIME_NS = 10_000;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] SETTLE_LOAD = SETTLE_CYCLES[7:0];
  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_ONE = 3'b001,
    MODE_TWO = 3'b010,
    MODE_THREE = 3'b011,
    MODE_FOUR = 3'b100,
    MODE_FIVE = 3'b101,
    MODE_INT_REF = 3'b110,
    MODE_OFF = 3'b111
  } dcc_mode_e;
  typedef struct packed {
    logic cmp2_invert;
    logic cmp1_invert;
    logic neg_input_switch;
    logic [2:0] cmp_mode_sel;
  } dcc_ctrl_s;
  typedef struct packed {
    logic cmp2_pos_ref;
    logic cmp1_pos_ref;
    logic [2:0] cmp2_neg_line;
    logic [2:0] cmp1_neg_line;
    logic [2:0] cmp2_pos_line;
    logic [2:0] cmp1_pos_line;
    logic cmp2_enable;
    logic cmp1_enable;
  } dcc_route_s;
  localparam logic [2:0] LINE_NONE = 3'h0;
  localparam logic [2:0] LINE_ONE = 3'h1;
  localparam logic [2:0] LINE_TWO = 3'h2;
  localparam logic [2:0] LINE_THREE = 3'h3;
  localparam logic [2:0] LINE_FOUR = 3'h4;
  localparam logic [2:0] LINE_FIVE = 3'h5;
  localparam logic [2:0] LINE_SIX = 3'h6;
endpackage

// ==== dcc_route.sv ====
// dual comparator control: mode to multiplexer select decode
// assumes the analog mux takes line numbers and reference-select levels
`timescale 1ns/1ps
`default_nettype none
module dcc_route (
  // control
  input wire dcc_pkg::dcc_ctrl_s ctrl_i,
  // mux selects
  output dcc_pkg::dcc_route_s route_o
);
  import dcc_pkg::*;
  dcc_mode_e mode;
  dcc_route_s r;
  assign mode = dcc_mode_e'(ctrl_i.cmp_mode_sel);
  always_comb
  begin
    r = '0;
    r.cmp1_enable = 1'b1;
    r.cmp2_enable = 1'b1;
    r.cmp1_pos_line = LINE_FIVE;
    r.cmp1_neg_line = LINE_SIX;
    r.cmp2_pos_line = LINE_THREE;
    r.cmp2_neg_line = LINE_FOUR;
    case (mode)
      MODE_RESET:
      begin
        r.cmp1_enable = 1'b0;
        r.cmp2_enable = 1'b0;
      end
      MODE_ONE:
      begin
        r.cmp1_neg_line = LINE_FIVE;
        r.cmp1_pos_line = LINE_SIX;
      end
      MODE_TWO:
      begin
        r.cmp2_neg_line = LINE_THREE;
        r.cmp2_pos_line = LINE_FOUR;
      end
      MODE_THREE:
      begin
        r.cmp1_neg_line = LINE_SIX;
        r.cmp2_neg_line = LINE_SIX;
      end
      MODE_FOUR:
      begin
        r.cmp1_pos_line = LINE_TWO;
        r.cmp2_pos_line = LINE_ONE;
      end
      MODE_FIVE:
      begin
        r.cmp1_enable = 1'b0;
        r.cmp1_pos_line = LINE_NONE;
        r.cmp1_neg_line = LINE_NONE;
      end
      MODE_INT_REF:
      begin
        r.cmp1_pos_ref = 1'b1;
        r.cmp2_pos_ref = 1'b1;
        r.cmp1_pos_line = LINE_NONE;
        r.cmp2_pos_line = LINE_NONE;
        r.cmp1_neg_line = ctrl_i.neg_input_switch ? LINE_FIVE : LINE_SIX;
        r.cmp2_neg_line = ctrl_i.neg_input_switch ? LINE_THREE : LINE_FOUR;
      end
      MODE_OFF:
      begin
        r = '0;
      end
      default:
      begin
        r = '0;
      end
    endcase
  end
  assign route_o = r;
endmodule // dcc_route
`default_nettype wire

// ==== dcc_props.sv ====
// checker for dcc_top: assertions on its ports
// assumes one clock mclk_i and async active low rst_n_i
`timescale 1ns/1ps
`default_nettype none
module dcc_props (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic cmp1_raw_i,
  input wire logic cmp2_raw_i,
  input wire dcc_pkg::dcc_route_s route_o,
  input wire logic cmp1_out_o,
  input wire logic cmp2_out_o,
  input wire logic [7:0] port_f_direction_i,
  input wire logic [7:0] port_f_direction_o,
  input wire logic result_valid_o,
  input wire logic cmp_change_flag_o,
  input wire logic irq_o
);
  import dcc_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire ctrl_rd = rd_i && (addr_i == ADDR_CTRL);
  wire ctrl_wr = wr_i && (addr_i == ADDR_CTRL);
  wire [2:0] md = rdata_o[2:0];
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_off; ctrl_rd ##1 (md == 3'h7 || md == 3'h0) |-> !route_o.cmp1_enable
    && !route_o.cmp2_enable; endproperty
  a_off: assert property (p_off) else $error("comparator enabled when off");
  property p_ref; ctrl_rd ##1 md == 3'h6 |-> route_o.cmp1_pos_ref && route_o.cmp2_pos_ref
    && route_o.cmp1_neg_line == (rdata_o[3] ? LINE_FIVE : LINE_SIX)
    && route_o.cmp2_neg_line == (rdata_o[3] ? LINE_THREE : LINE_FOUR); endproperty
  a_ref: assert property (p_ref) else $error("reference mode routing wrong");
  property p_out1; ctrl_rd |=> cmp1_out_o == (cmp1_raw_i ^ rdata_o[4]); endproperty
  a_out1: assert property (p_out1) else $error("output one polarity wrong");
  property p_out2; ctrl_rd |=> cmp2_out_o == (cmp2_raw_i ^ rdata_o[5]); endproperty
  a_out2: assert property (p_out2) else $error("output two polarity wrong");
  property p_dir; port_f_direction_o == port_f_direction_i; endproperty
  a_dir: assert property (p_dir) else $error("direction altered");
  property p_irq; irq_o |-> cmp_change_flag_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without flag");
  property p_fall; $fell(result_valid_o) |-> $past(ctrl_wr); endproperty
  a_fall: assert property (p_fall) else $error("valid fell without write");
  property p_hold; $fell(result_valid_o) |-> !result_valid_o [*8]; endproperty
  a_hold: assert property (p_hold) else $error("valid returned early");
  c_settle: cover property ($fell(result_valid_o));
  c_irq: cover property (irq_o);
  c_ref: cover property (ctrl_rd ##1 md == 3'h6);
endmodule // dcc_props
bind dcc_top dcc_props u_props (.*);
`default_nettype wire

// ==== dcc_cmp_model.sv ====
// analog comparator pair model: compare levels to raw outputs
// assumes the bench sets which input is higher; an unpowered comparator reads low
`timescale 1ns/1ps
`default_nettype none
module dcc_cmp_model (
  // routing from the block
  input wire dcc_pkg::dcc_route_s route_i,
  // vin+ above vin- per comparator
  input wire logic above1_i,
  input wire logic above2_i,
  // raw outputs
  output logic cmp1_raw_o,
  output logic cmp2_raw_o
);
  assign cmp1_raw_o = route_i.cmp1_enable & above1_i;
  assign cmp2_raw_o = route_i.cmp2_enable & above2_i;
endmodule // dcc_cmp_model
`default_nettype wire

// ==== test_dual_comparator_control.sv ====
// testbench for dcc_top with comparator model
// assumes 10 MHz clock and register port reads one cycle late
`timescale 1ns/1ps
`default_nettype none
module test_dual_comparator_control;
  import dcc_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic a1 = 1'b0;
  logic a2 = 1'b0;
  logic [7:0] port_f_direction_i = 8'ha5;
  logic [7:0] rdata_o, port_f_direction_o;
  logic cmp1_raw_i, cmp2_raw_i, cmp1_out_o, cmp2_out_o, result_valid_o, cmp_change_flag_o, irq_o;
  dcc_route_s route_o;
  int failures = 0;
  int checks = 0;
  int n;
  dcc_top uut (.*);
  dcc_cmp_model model (.route_i(route_o), .above1_i(a1), .above2_i(a2),
    .cmp1_raw_o(cmp1_raw_i), .cmp2_raw_o(cmp2_raw_i));
  initial
    forever #50 mclk_i = ~mclk_i;
  task check(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task set_above(input logic v1, input logic v2);
    @(posedge mclk_i);
    a1 <= v1;
    a2 <= v2;
    #1;
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, e);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_IRQ_MASK, IRQ_RESET);
    wr(ADDR_CTRL, 8'hc0);
    rd(ADDR_CTRL, 8'h00);
    $display("reset test done");
    set_above(1'b1, 1'b0);
    wr(ADDR_CTRL, 8'h06);
    tick(3);
    rd(ADDR_CTRL, 8'h46);
    wr(ADDR_CTRL, 8'h3e);
    tick(3);
    rd(ADDR_CTRL, 8'hbe);
    $display("result test done");
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    check(8'(cmp_change_flag_o), 8'h00);
    set_above(1'b0, 1'b0);
    tick(4);
    check(8'(irq_o), 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    check(8'(cmp_change_flag_o), 8'h01);
    rd(ADDR_CTRL, 8'hfe);
    wr(ADDR_IRQ_STATUS, 8'h01);
    check(8'(irq_o), 8'h00);
    wr(ADDR_IRQ_MASK, 8'h00);
    set_above(1'b0, 1'b1);
    tick(4);
    rd(ADDR_IRQ_STATUS, 8'h01);
    check(8'(irq_o), 8'h00);
    $display("flag test done");
    set_above(1'b0, 1'b0);
    @(posedge mclk_i);
    port_f_direction_i <= 8'h5a;
    tick(110);
    check(port_f_direction_o, 8'h5a);
    for (int m = 0; m < 8; m++)
    begin
      wr(ADDR_CTRL, 8'(m));
      rd(ADDR_CTRL, 8'(m));
    end
    tick(110);
    wr(ADDR_CTRL, 8'h06);
    check(8'(result_valid_o), 8'h00);
    n = 0;
    while (result_valid_o !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
    check(8'(n), SETTLE_LOAD);
    wr(ADDR_SETTLE, 8'hff);
    rd(ADDR_SETTLE, 8'h00);
    $display("mode test done");
    report_and_stop();
  end
endmodule // test_dual_comparator_control
`default_nettype wire
